// [hdl/qos_snoop_regs.vh]
// Register offsets, field positions and reset values of the global QoS and snooping registers.
`ifndef QOS_SNOOP_REGS_VH
`define QOS_SNOOP_REGS_VH
// Printed offsets are not all multiples of four: each is a word index, byte address is index times four.
`define IDX_DSCP_MAP_3C_3D 12'h35e
`define IDX_DSCP_MAP_3E_3F 12'h35f
`define IDX_MIRROR_SNOOP 12'h370
`define IDX_WRED_COLOUR 12'h378
`define IDX_QUEUE_MGMT 12'h390
`define ADDR_W 14
`define PRIO_LO_LSB 0
`define PRIO_HI_LSB 4
`define SNOOP_IGMP_BIT 6
`define SNOOP_MLD_OPT_BIT 3
`define SNOOP_MLD_EN_BIT 2
`define SNIFF_AND_BIT 0
`define MIRROR_SNOOP_MASK 8'h4d
`define DSCP_MAP_MASK 8'h77
`define WRED_MASK 8'h3f
`define WRED_RST 8'h39
`define QUEUE_MGMT_MASK 32'h000000ff
`define QUEUE_MGMT_RST 32'h00000082
`define FOLD_LSB 6
`define UCAST_DISCARD_BIT 1
`define DSCP_3C 6'h3c
`define DSCP_3D 6'h3d
`define DSCP_3E 6'h3e
`define DSCP_3F 6'h3f
`define NH_HOP 8'h00
`define NH_ICMP 8'h01
`define NH_ICMP6 8'h3a
`define NH_ROUTE 8'h2b
`define NH_FRAG 8'h2c
`define NH_ESP 8'h32
`define NH_AH 8'h33
`define NH_DEST 8'h3c
`endif

// [hdl/qos_snoop_regs.v]
// Global QoS, snooping, mirroring and queue-folding registers with their decision logic.
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/1ps
`include "qos_snoop_regs.vh"
// Functional notes
// [RQ1] DSCP 3C/3D priority from first map
// [RQ2] DSCP 3E/3F priority from second map
// [RQ3] IGMP snoop enable sends to host
// [RQ4] MLD snoop enable sends to host
// [RQ5] Option set: extension-header next headers qualify
// [RQ6] Option clear: ICMP next headers qualify
// [RQ7] Sniff select set: source and destination
// [RQ8] Sniff select clear: source or destination
// [RQ9] Red colour field, reset 11b
// [RQ10] Yellow colour field, reset 10b
// [RQ11] Green colour field, reset 01b
// [RQ12] Fold applies only in two-queue mode
// [RQ13] Fold 00: only priority 3 high
// [RQ14] Fold 10 reset: priorities 2,3 high
// [RQ15] Fold 11: priorities 1-3 high
// [RQ16] Discard set: limit to membership ports
// [RQ17] Discard clear: single destination unlimited
// [RQ18] Mirrored single destination dropped when clear
// [RQ19] Reserved bits read zero, writes ignored
module qos_snoop_regs #(
  parameter PORTS = 7
) (
  input wire CORE_CLK_I,
  input wire ARST_N_I,
  input wire [`ADDR_W-1:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  output reg [1:0] AVS_RESPONSE_O,
  // Frame classification inputs from the same clock domain.
  input wire [5:0] DSCP_I,
  input wire IS_IP_I,
  input wire IS_IGMP_I,
  input wire IS_IPV6_I,
  input wire [7:0] NEXT_HDR_I,
  input wire [7:0] HOP_NEXT_HDR_I,
  input wire SRC_SNIFFED_I,
  input wire DST_SNIFFED_I,
  input wire [1:0] REGEN_PRIO_I,
  input wire TWO_QUEUE_MODE_I,
  input wire [PORTS-1:0] DEST_PORTS_I,
  input wire [PORTS-1:0] MEMBER_PORTS_I,
  input wire MIRROR_ACTIVE_I,
  output reg [2:0] DSCP_PRIO_O,
  output reg DSCP_PRIO_HIT_O,
  output reg TO_HOST_O,
  output reg MIRROR_O,
  output reg HIGH_QUEUE_O,
  output reg [PORTS-1:0] FWD_PORTS_O,
  output reg DROP_O,
  output reg [1:0] WRED_RED_O,
  output reg [1:0] WRED_YELLOW_O,
  output reg [1:0] WRED_GREEN_O
);

// ==========================================================================
// Register bus slave
// ==========================================================================
reg [7:0] map_3c_q;
reg [7:0] map_3e_q;
reg [7:0] snoop_q;
reg [7:0] wred_q;
reg [31:0] qmgmt_q;
reg ack_q;
// Word index from the byte address; the two low address bits are ignored.
wire [11:0] idx = AVS_ADDRESS_I[`ADDR_W-1:2];
wire req = (AVS_READ_I | AVS_WRITE_I) & ~ack_q;
wire hit_3c = idx == `IDX_DSCP_MAP_3C_3D;
wire hit_3e = idx == `IDX_DSCP_MAP_3E_3F;
wire hit_sn = idx == `IDX_MIRROR_SNOOP;
wire hit_wr = idx == `IDX_WRED_COLOUR;
wire hit_qm = idx == `IDX_QUEUE_MGMT;
wire hit_any = hit_3c | hit_3e | hit_sn | hit_wr | hit_qm;
// Only byte lane 0 carries live bits, so its enable alone gates a write.
wire wr = req & AVS_WRITE_I & AVS_BYTEENABLE_I[0];
reg [31:0] rd_d;

// [RQ19] Reserved read zero.
always @* begin
  rd_d = 32'h00000000;
  if (hit_3c) rd_d = {24'h000000, map_3c_q};
  if (hit_3e) rd_d = {24'h000000, map_3e_q};
  if (hit_sn) rd_d = {24'h000000, snoop_q};
  if (hit_wr) rd_d = {24'h000000, wred_q};
  if (hit_qm) rd_d = qmgmt_q;
end

// One wait cycle on every access; the answer comes on the second edge of the request.
// The ack flag blocks a second take of the same request while the master still holds it.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    ack_q <= 1'b0;
    AVS_WAITREQUEST_O <= 1'b1;
  end else begin
    ack_q <= req;
    AVS_WAITREQUEST_O <= ~req;
  end
end

// Read data and response hold until the next access is taken.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    AVS_READDATA_O <= 32'h00000000;
    AVS_RESPONSE_O <= 2'h0;
  end else if (req) begin
    AVS_READDATA_O <= AVS_READ_I ? rd_d : 32'h00000000;
    AVS_RESPONSE_O <= hit_any ? 2'h0 : 2'h3;
  end
end

// [RQ1] First priority map.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    map_3c_q <= 8'h00;
  end else if (wr & hit_3c) begin
    // [RQ19] Reserved writes ignored.
    map_3c_q <= AVS_WRITEDATA_I[7:0] & `DSCP_MAP_MASK;
  end
end

// [RQ2] Second priority map.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    map_3e_q <= 8'h00;
  end else if (wr & hit_3e) begin
    // [RQ19] Reserved writes ignored.
    map_3e_q <= AVS_WRITEDATA_I[7:0] & `DSCP_MAP_MASK;
  end
end

// [RQ3] [RQ4] Snoop and sniff controls.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    snoop_q <= 8'h00;
  end else if (wr & hit_sn) begin
    // [RQ19] Reserved writes ignored.
    snoop_q <= AVS_WRITEDATA_I[7:0] & `MIRROR_SNOOP_MASK;
  end
end

// [RQ9] [RQ10] [RQ11] Colour fields, resets.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    wred_q <= `WRED_RST;
  end else if (wr & hit_wr) begin
    // [RQ19] Reserved writes ignored.
    wred_q <= AVS_WRITEDATA_I[7:0] & `WRED_MASK;
  end
end

// [RQ12] [RQ16] Fold and discard controls.
// Bits 5:2 and 0 are read/write storage with no effect on forwarding.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    qmgmt_q <= `QUEUE_MGMT_RST;
  end else if (wr & hit_qm) begin
    // [RQ19] Upper reserved bits ignored.
    qmgmt_q <= {24'h000000, AVS_WRITEDATA_I[7:0]} & `QUEUE_MGMT_MASK;
  end
end

// ==========================================================================
// Frame decisions
// ==========================================================================
function ext_hdr;
  input [7:0] nh;
  begin
    ext_hdr = (nh == `NH_ROUTE) |
              (nh == `NH_FRAG) |
              (nh == `NH_ESP) |
              (nh == `NH_AH) |
              (nh == `NH_DEST);
  end
endfunction

function icmp_hdr;
  input [7:0] nh;
  begin
    icmp_hdr = (nh == `NH_ICMP) |
               (nh == `NH_ICMP6);
  end
endfunction

reg [2:0] prio_d;
reg prio_hit_d;
reg mld_d;
reg high_d;
reg fold_high;
// Single destination means exactly one bit set: clearing the lowest set bit must leave nothing.
wire ucast = (DEST_PORTS_I != {PORTS{1'b0}}) & ((DEST_PORTS_I & (DEST_PORTS_I - 1'b1)) == {PORTS{1'b0}});
wire discard = qmgmt_q[`UCAST_DISCARD_BIT];
wire [1:0] fold = qmgmt_q[`FOLD_LSB+1:`FOLD_LSB];
wire ext_direct = ext_hdr(NEXT_HDR_I);
wire ext_hop = (NEXT_HDR_I == `NH_HOP) & ext_hdr(HOP_NEXT_HDR_I);
wire icmp_direct = icmp_hdr(NEXT_HDR_I);
wire icmp_hop = (NEXT_HDR_I == `NH_HOP) & icmp_hdr(HOP_NEXT_HDR_I);

// [RQ1] [RQ2] DSCP priority lookup.
always @* begin
  prio_d = 3'h0;
  prio_hit_d = IS_IP_I;
  case (DSCP_I)
    `DSCP_3C: prio_d = map_3c_q[`PRIO_LO_LSB+2:`PRIO_LO_LSB];
    `DSCP_3D: prio_d = map_3c_q[`PRIO_HI_LSB+2:`PRIO_HI_LSB];
    `DSCP_3E: prio_d = map_3e_q[`PRIO_LO_LSB+2:`PRIO_LO_LSB];
    `DSCP_3F: prio_d = map_3e_q[`PRIO_HI_LSB+2:`PRIO_HI_LSB];
    default: prio_hit_d = 1'b0;
  endcase
end

// [RQ5] [RQ6] MLD criteria select.
always @* begin
  mld_d = 1'b0;
  if (snoop_q[`SNOOP_MLD_OPT_BIT]) begin
    mld_d = ext_direct | ext_hop;
  end else begin
    mld_d = icmp_direct | icmp_hop;
  end
end

// [RQ13] [RQ14] [RQ15] Fold codes.
// Code 01 is not for software; it folds like 00 so a stray write still gives a defined queue.
always @* begin
  fold_high = 1'b0;
  case (fold)
    2'h3: fold_high = REGEN_PRIO_I != 2'h0;
    2'h2: fold_high = REGEN_PRIO_I[1];
    2'h1: fold_high = REGEN_PRIO_I == 2'h3;
    default: fold_high = REGEN_PRIO_I == 2'h3;
  endcase
end

// [RQ12] Fold only in two-queue mode.
always @* begin
  high_d = TWO_QUEUE_MODE_I & fold_high;
end

// ==========================================================================
// Registered frame outputs
// ==========================================================================
// Each output has its own register, so every top-level output comes straight from a flip-flop.
// [RQ3] IGMP snoop qualify.
wire igmp_snoop = snoop_q[`SNOOP_IGMP_BIT] & IS_IGMP_I;
// [RQ4] MLD snoop qualify.
wire mld_snoop = snoop_q[`SNOOP_MLD_EN_BIT] & IS_IPV6_I & mld_d;
// [RQ7] Both sides match.
wire sniff_and = SRC_SNIFFED_I & DST_SNIFFED_I;
// [RQ8] Either side matches.
wire sniff_or = SRC_SNIFFED_I | DST_SNIFFED_I;
// Frames with several destinations are always limited, whatever the discard bit says.
wire limit = discard | ~ucast;
// [RQ18] Mirrored unicast drop.
wire drop_d = ~discard & ucast & MIRROR_ACTIVE_I;
wire [PORTS-1:0] fwd_d;
genvar p;

// The per-port mask is one gate per port, so the generated loop stays flat.
generate
  for (p = 0; p < PORTS; p = p + 1) begin : g_fwd
    // [RQ16] [RQ17] Port forward gate.
    assign fwd_d[p] = DEST_PORTS_I[p] & (MEMBER_PORTS_I[p] | ~limit);
  end
endgenerate

// [RQ1] [RQ2] Priority lookup result.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    DSCP_PRIO_O <= 3'h0;
    DSCP_PRIO_HIT_O <= 1'b0;
  end else begin
    DSCP_PRIO_O <= prio_d;
    DSCP_PRIO_HIT_O <= prio_hit_d;
  end
end

// [RQ3] [RQ4] Snoop to host.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    TO_HOST_O <= 1'b0;
  end else begin
    TO_HOST_O <= igmp_snoop | mld_snoop;
  end
end

// [RQ7] [RQ8] Sniff filter mode.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    MIRROR_O <= 1'b0;
  end else if (snoop_q[`SNIFF_AND_BIT]) begin
    MIRROR_O <= sniff_and;
  end else begin
    MIRROR_O <= sniff_or;
  end
end

// [RQ12] Folded queue select.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    HIGH_QUEUE_O <= 1'b0;
  end else begin
    HIGH_QUEUE_O <= high_d;
  end
end

// [RQ16] [RQ17] Forwarding set.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    FWD_PORTS_O <= {PORTS{1'b0}};
  end else begin
    FWD_PORTS_O <= fwd_d;
  end
end

// [RQ18] Drop flag.
// Drop is a level for the frame seen at the inputs one cycle earlier.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    DROP_O <= 1'b0;
  end else begin
    DROP_O <= drop_d;
  end
end

// [RQ9] [RQ10] [RQ11] Colour outputs.
// Colour fields go out as levels so downstream logic needs no bus access.
always @(posedge CORE_CLK_I or negedge ARST_N_I) begin
  if (!ARST_N_I) begin
    WRED_RED_O <= 2'h3;
    WRED_YELLOW_O <= 2'h2;
    WRED_GREEN_O <= 2'h1;
  end else begin
    WRED_RED_O <= wred_q[5:4];
    WRED_YELLOW_O <= wred_q[3:2];
    WRED_GREEN_O <= wred_q[1:0];
  end
end

endmodule // qos_snoop_regs

// [tb/qos_snoop_checker.sv]
// Port-level assertions for the QoS and snooping register block.
`timescale 1ns/1ps
module qos_snoop_checker #(parameter PORTS = 7) (
  input logic CORE_CLK_I, ARST_N_I, IS_IP_I, IS_IGMP_I, IS_IPV6_I, SRC_SNIFFED_I, DST_SNIFFED_I,
  input logic [5:0] DSCP_I, input logic [1:0] REGEN_PRIO_I, input logic TWO_QUEUE_MODE_I, MIRROR_ACTIVE_I,
  input logic DSCP_PRIO_HIT_O, TO_HOST_O, MIRROR_O, HIGH_QUEUE_O, DROP_O,
  input logic [PORTS-1:0] DEST_PORTS_I, FWD_PORTS_O
);
  // ====================
  // Frame path checks
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_hit; IS_IP_I && DSCP_I[5:2] == 4'hf |=> DSCP_PRIO_HIT_O; endproperty
  a_hit: assert property (p_hit) else $error("priority hit missing");
  property p_miss; !IS_IP_I || DSCP_I[5:2] != 4'hf |=> !DSCP_PRIO_HIT_O; endproperty
  a_miss: assert property (p_miss) else $error("stray priority hit");
  property p_host; TO_HOST_O |-> $past(IS_IGMP_I) || $past(IS_IPV6_I); endproperty
  a_host: assert property (p_host) else $error("host forward without snoop frame");
  property p_both; SRC_SNIFFED_I && DST_SNIFFED_I |=> MIRROR_O; endproperty
  a_both: assert property (p_both) else $error("mirror missing");
  property p_none; !SRC_SNIFFED_I && !DST_SNIFFED_I |=> !MIRROR_O; endproperty
  a_none: assert property (p_none) else $error("mirror without match");
  property p_mode; !TWO_QUEUE_MODE_I |=> !HIGH_QUEUE_O; endproperty
  a_mode: assert property (p_mode) else $error("fold outside two-queue mode");
  property p_top; TWO_QUEUE_MODE_I && REGEN_PRIO_I == 2'h3 |=> HIGH_QUEUE_O; endproperty
  a_top: assert property (p_top) else $error("priority 3 not high");
  property p_low; TWO_QUEUE_MODE_I && REGEN_PRIO_I == 2'h0 |=> !HIGH_QUEUE_O; endproperty
  a_low: assert property (p_low) else $error("priority 0 not low");
  property p_fwd; 1'b1 |=> (FWD_PORTS_O & ~$past(DEST_PORTS_I)) == '0; endproperty
  a_fwd: assert property (p_fwd) else $error("forward beyond destinations");
  property p_drop; DROP_O |-> $past(MIRROR_ACTIVE_I) && $onehot($past(DEST_PORTS_I)); endproperty
  a_drop: assert property (p_drop) else $error("drop without mirrored single frame");
endmodule // qos_snoop_checker

// [tb/qos_snoop_regs_tb.sv]
// Self-checking bench with a reference model of the QoS and snooping register block.
`timescale 1ns/1ps
bind qos_snoop_regs qos_snoop_checker #(.PORTS(PORTS)) u_qos_snoop_checker (.*);
module qos_snoop_regs_tb;
  // ====================
  // Stimulus and model state
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, ip = 0, igmp = 0, v6 = 0, src = 0, dst = 0, tq = 0, mact = 0;
  logic [13:0] adr = 0;
  logic [31:0] wd = 0, rdat, d;
  logic [3:0] be = 0, b;
  logic [5:0] dscp = 0;
  logic [7:0] nh = 0, hh = 0;
  logic [1:0] rsp, prio = 0, red, yel, grn;
  logic [6:0] dest = 0, mem = 0, fwd;
  logic [2:0] dpr;
  logic wq, hit, host, mir, hq, drop;
  logic [13:0] ra [5] = '{14'hd78, 14'hd7c, 14'hdc0, 14'hde0, 14'he40};
  logic [7:0] msk [5] = '{8'h77, 8'h77, 8'h4d, 8'h3f, 8'hff};
  logic [7:0] m [5] = '{8'h00, 8'h00, 8'h00, 8'h39, 8'h82};
  logic [7:0] nhs [8] = '{8'h00, 8'h01, 8'h3a, 8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c};
  int err_count = 0, samples_checked = 0;
  qos_snoop_regs u_qos_snoop_regs (.CORE_CLK_I(clk), .ARST_N_I(rst_n), .AVS_ADDRESS_I(adr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wd), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdat), .AVS_WAITREQUEST_O(wq),
    .AVS_RESPONSE_O(rsp), .DSCP_I(dscp), .IS_IP_I(ip), .IS_IGMP_I(igmp), .IS_IPV6_I(v6), .NEXT_HDR_I(nh),
    .HOP_NEXT_HDR_I(hh), .SRC_SNIFFED_I(src), .DST_SNIFFED_I(dst), .REGEN_PRIO_I(prio), .TWO_QUEUE_MODE_I(tq),
    .DEST_PORTS_I(dest), .MEMBER_PORTS_I(mem), .MIRROR_ACTIVE_I(mact), .DSCP_PRIO_O(dpr), .DSCP_PRIO_HIT_O(hit),
    .TO_HOST_O(host), .MIRROR_O(mir), .HIGH_QUEUE_O(hq), .FWD_PORTS_O(fwd), .DROP_O(drop), .WRED_RED_O(red),
    .WRED_YELLOW_O(yel), .WRED_GREEN_O(grn));
  initial forever #5 clk = ~clk;
  function automatic bit ok(input bit o, input logic [7:0] n);
    return o ? n inside {8'h2b, 8'h2c, 8'h32, 8'h33, 8'h3c} : n inside {8'h01, 8'h3a};
  endfunction
  task chk(input string n, input logic [31:0] g, e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Each access starts one edge after the last release, so no signal is driven twice in a time step.
  task bus(input logic w, input logic [13:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk);
    {adr, wd, wr, rd} <= {a, v, w, !w};
    do @(posedge clk); while (wq !== 1'b0 && ++n < 20);
    if (n == 20) err_count++;
    {rd, wr} <= 2'h0;
  endtask
  task frame;
    @(posedge clk);
    {ip, src, dst, prio, tq, mact, mem} <= 14'($urandom);
    {igmp, v6} <= 2'($urandom % 3);
    dscp <= {($urandom % 2) ? 4'hf : 4'($urandom), 2'($urandom)};
    {nh, hh} <= {nhs[$urandom % 8], nhs[$urandom % 8]};
    dest <= ($urandom % 2) ? 7'(1 << ($urandom % 7)) : 7'($urandom);
    @(posedge clk);
    #1;
    chk("host", host, igmp & m[2][6] | v6 & m[2][2] & (ok(m[2][3], nh) | nh == 0 & ok(m[2][3], hh)));
    chk("mirror", mir, m[2][0] ? src & dst : src | dst);
    chk("hit", hit, ip & dscp[5:2] == 4'hf);
    if (hit === 1'b1) chk("prio", dpr, (m[dscp[1]] >> (4 * dscp[0])) & 8'h07);
    chk("queue", hq, tq & (m[4][7:6] == 3 ? prio != 0 : m[4][7:6] == 2 ? prio[1] : prio == 3));
    chk("fwd", fwd, !m[4][1] && $onehot(dest) ? dest : dest & mem);
    chk("drop", drop, !m[4][1] & $onehot(dest) & mact);
    chk("wred", {red, yel, grn}, m[3][5:0]);
  endtask
  initial begin
    int k;
    void'($urandom(32'hd9f3));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("reset", rdat, m[i]);
    end
    bus(1'b0, 14'h0004, 32'h0);
    chk("unmapped", rsp, 2'h3);
    chk("unmapped data", rdat, 32'h0);
    repeat (400) begin
      if ($urandom % 4 == 0) begin
        k = $urandom % 5;
        b = 4'($urandom);
        d = $urandom;
        be <= b;
        bus(1'b1, ra[k], d);
        if (b[0]) m[k] = d[7:0] & msk[k];
        bus(1'b0, ra[k], 32'h0);
        chk("readback", rdat, m[k]);
        chk("response", rsp, 2'h0);
      end
      frame();
    end
    // A second reset in mid-run must bring every register back to its reset value.
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    m = '{8'h00, 8'h00, 8'h00, 8'h39, 8'h82};
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0);
      chk("rereset", rdat, m[i]);
    end
    repeat (20) frame();
    summarize();
  end
  initial begin
    #100us;
    err_count++;
    summarize();
  end
endmodule // qos_snoop_regs_tb
